/* inc/vrs_defs.vh */
/*
 Constants for the reference stepper: code widths, the shutdown code,
 set-point scale in millivolts and the step timing in switching cycles.
 Assumes inclusion by bare name from the design files.
*/
`ifndef VRS_DEFS_VH
`define VRS_DEFS_VH

`define VRS_CODE_W 5
`define VRS_CODE_SHUTDOWN 5'h1F
`define VRS_CODE_RESET 5'h1F
`define VRS_MV_W 11
`define VRS_MV_TOP 11'h60E
`define VRS_MV_BOTTOM 11'h320
`define VRS_MV_STEP 11'h019
`define VRS_CYC_PER_STEP 2'h2
`define VRS_VALID_CYCLES 1'h1

`endif

/* tb/tb_top.sv */
/* Self-checking bench for the stepper. Assumes ticks every four clocks. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [4:0] c; logic [10:0] mv;} vrs_row_t;
    vrs_row_t rows [4] = '{'{5'h00, 11'h60E}, '{5'h1E, 11'h320}, '{5'h08, 11'h546}, '{5'h0E, 11'h4B0}};
    logic clk = 0, rst = 1, tick = 0, ce = 1;
    logic [4:0] want = 5'h1F, code;
    wire [10:0] ref_mv;
    wire shut, stp;
    wire [4:0] acc;
    int n_fail = 0, tests_run = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    vrs_cpu_model u_vrs_cpu_model (.clk(clk), .want(want), .code(code));
    vrs_reference_stepper u_vrs_reference_stepper (.clk(clk), .rst(rst), .ce(ce), .cycle_tick(tick),
        .voltage_ident_code(code), .reference_mv(ref_mv), .shutdown(shut), .stepping(stp), .accepted_code(acc));
    task chk_mv(input logic [10:0] g, input logic [10:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t reference got %h exp %h", $time, g, e);
        end
    endtask
    task chk_code(input logic [4:0] g, input logic [4:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t accepted code got %h exp %h", $time, g, e);
        end
    endtask
    task chk_flag(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t flag got %b exp %b", $time, g, e);
        end
    endtask
    task tk(input int n);
        repeat (n) begin
            @(posedge clk) #1 tick = 1;
            @(posedge clk) #1 tick = 0;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task walk;
        for (int k = 0; k < 80 && stp === 1'b1; k++) tk(1);
    endtask
    task report_and_stop;
        if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 0;
        chk_flag(shut, 1'b1);
        chk_code(acc, 5'h1F);
        chk_mv(ref_mv, 11'h320);
        chk_flag(stp, 1'b0);
        foreach (rows[i]) begin
            want = rows[i].c;
            tk(2);
            chk_code(acc, rows[i].c);
            walk();
            chk_mv(ref_mv, rows[i].mv);
            chk_flag(stp, 1'b0);
        end
        want = 5'h06;
        tk(1);
        chk_code(acc, 5'h0E);
        tk(1);
        chk_code(acc, 5'h06);
        chk_flag(stp, 1'b1);
        tk(1);
        chk_mv(ref_mv, 11'h4B0);
        tk(1);
        chk_mv(ref_mv, 11'h4C9);
        want = 5'h00;
        tk(1);
        chk_flag(stp, 1'b1);
        want = 5'h06;
        tk(2);
        chk_code(acc, 5'h06);
        walk();
        chk_mv(ref_mv, 11'h578);
        want = 5'h0A;
        tk(1);
        want = 5'h0C;
        tk(1);
        chk_code(acc, 5'h06);
        tk(1);
        chk_code(acc, 5'h0C);
        walk();
        chk_mv(ref_mv, 11'h4E2);
        ce = 0;
        want = 5'h1F;
        tk(2);
        chk_code(acc, 5'h0C);
        ce = 1;
        tk(2);
        chk_flag(shut, 1'b1);
        chk_mv(ref_mv, 11'h4E2);
        want = 5'h08;
        tk(2);
        chk_flag(shut, 1'b0);
        chk_flag(stp, 1'b1);
        @(posedge clk) #1 rst = 1;
        repeat (3) @(posedge clk);
        #1 rst = 0;
        chk_mv(ref_mv, 11'h320);
        chk_flag(shut, 1'b1);
        chk_code(acc, 5'h1F);
        chk_flag(stp, 1'b0);
        report_and_stop();
    end
endmodule // tb_top

/* tb/vrs_cpu_model.sv */
/* Processor model driving the identification inputs. Assumes the bench names the wanted code. */
module vrs_cpu_model (
    input wire clk,
    input wire [4:0] want,
    output logic [4:0] code
);
    timeunit 1ns;
    timeprecision 1ns;
    initial code = 5'h1F;
    always @(posedge clk) code <= #1 want;
endmodule // vrs_cpu_model

/* tb/vrs_stepper_props.sv */
/* Port checker for the reference stepper. Assumes bind to every stepper instance. */
module vrs_stepper_props (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire cycle_tick,
    input wire [4:0] voltage_ident_code,
    input wire [10:0] reference_mv,
    input wire shutdown,
    input wire stepping,
    input wire [4:0] accepted_code
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [10:0] tgt = 11'h60E - 11'h019 * accepted_code;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ref_range: assert property (reference_mv >= 11'h320 && reference_mv <= 11'h60E) else $error("ref range");
    a_shut_flag: assert property (shutdown == (accepted_code == 5'h1F)) else $error("shutdown flag");
    a_hold_off_tick: assert property (!(cycle_tick && ce) |=> $stable(reference_mv) && $stable(accepted_code))
        else $error("change off tick");
    a_step_on_tick: assert property ($changed(reference_mv) |-> $past(cycle_tick && ce)) else $error("step no tick");
    a_accept_valid: assert property ($changed(accepted_code) |-> $past(voltage_ident_code) == accepted_code)
        else $error("accept wrong code");
    a_step_size: assert property ($changed(reference_mv) |-> reference_mv == $past(reference_mv) + 11'h019
        || reference_mv + 11'h019 == $past(reference_mv)) else $error("step size");
    a_step_dir: assert property ($changed(reference_mv) |-> (reference_mv > $past(reference_mv))
        == ($past(reference_mv) < $past(tgt))) else $error("step direction");
    a_stop_target: assert property (!stepping && !shutdown |-> reference_mv == tgt) else $error("idle off target");
    c_walk_done: cover property ($fell(stepping));
    c_shut_in: cover property ($rose(shutdown));
    c_accept: cover property ($changed(accepted_code));
endmodule // vrs_stepper_props
bind vrs_reference_stepper vrs_stepper_props u_vrs_stepper_props (.clk(clk), .rst(rst), .ce(ce),
    .cycle_tick(cycle_tick), .voltage_ident_code(voltage_ident_code), .reference_mv(reference_mv),
    .shutdown(shutdown), .stepping(stepping), .accepted_code(accepted_code));

/* verilog/vrs_code_decode.v */
/*
 Identification code to reference set point decoder, in millivolts.
 Purely combinational; assumes a stable code at its input.
*/
`include "vrs_defs.vh"

module vrs_code_decode (
    input wire [`VRS_CODE_W-1:0] voltage_ident_code,
    output reg [`VRS_MV_W-1:0] set_point_mv,
    output reg shutdown_code
);
    // R1 code to millivolts
    always @* begin
        set_point_mv = `VRS_MV_TOP - `VRS_MV_STEP * {6'h00, voltage_ident_code};
        shutdown_code = 1'b0;
        // R2 all-ones shutdown
        if (voltage_ident_code == `VRS_CODE_SHUTDOWN) begin
            set_point_mv = `VRS_MV_BOTTOM;
            shutdown_code = 1'b1;
        end
    end
endmodule // vrs_code_decode

/* verilog/vrs_reference_stepper.v */
/*
 Reference stepper: samples the identification code once per switching
 cycle, validates a change over one full cycle, then walks the reference
 one 25 mV step every two cycles toward the new set point.
 Assumes cycle_tick is a one-clock pulse from the internal phase clock at
 each channel-1 pulse termination, synchronous to clk.
*/
`include "vrs_defs.vh"

// Functional notes
// R1 - Code zero gives 1550 mV; each code step lowers 25 mV to 800 mV.
// R2 - All-ones code means shutdown; any other code restarts; not for loaded enable.
// R3 - A switching cycle spans successive channel-1 pulse-termination ticks.
// R4 - Sample code only at each cycle start; compare with accepted code.
// R5 - A differing sample holds reference for one whole validation cycle.
// R6 - Act only if code stayed the same across the whole validation cycle.
// R7 - After validation, move reference 25 mV every two cycles until matched.
// R8 - Step down if target lower, up if higher, stop when equal.
module vrs_reference_stepper (
    clk,
    rst,
    ce,
    cycle_tick,
    voltage_ident_code,
    reference_mv,
    shutdown,
    stepping,
    accepted_code
);
    input wire clk;
    input wire rst;
    input wire ce;
    input wire cycle_tick;
    input wire [`VRS_CODE_W-1:0] voltage_ident_code;
    output reg [`VRS_MV_W-1:0] reference_mv;
    output reg shutdown;
    output reg stepping;
    output reg [`VRS_CODE_W-1:0] accepted_code;

    localparam ST_IDLE = 2'h0;
    localparam ST_VALID = 2'h1;
    localparam ST_STEP = 2'h2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [`VRS_CODE_W-1:0] cand_r;
    reg [`VRS_CODE_W-1:0] cand_nxt;
    reg [`VRS_CODE_W-1:0] acc_nxt;
    reg [1:0] cyc_r;
    reg [1:0] cyc_nxt;
    reg [`VRS_MV_W-1:0] ref_nxt;
    reg [`VRS_MV_W-1:0] target_r;
    reg [`VRS_MV_W-1:0] target_nxt;
    reg shut_nxt;
    reg stepping_nxt;

    wire [`VRS_MV_W-1:0] cand_mv;
    wire cand_shut;
    wire code_new;
    wire code_held;
    wire step_due;
    wire walk_left;

    // R1 set point decode
    vrs_code_decode u_dec (
        .voltage_ident_code(cand_r),
        .set_point_mv(cand_mv),
        .shutdown_code(cand_shut)
    );

    // Next reference one step toward the target; holds once equal
    function [`VRS_MV_W-1:0] step_toward;
        input [`VRS_MV_W-1:0] cur;
        input [`VRS_MV_W-1:0] tgt;
        begin
            if (tgt < cur) begin
                step_toward = cur - `VRS_MV_STEP;
            end else if (tgt > cur) begin
                step_toward = cur + `VRS_MV_STEP;
            end else begin
                step_toward = cur;
            end
        end
    endfunction

    // Cadence count after one more cycle, wrapping at the step period
    function [1:0] cadence_next;
        input [1:0] cnt;
        begin
            if (cnt + 2'h1 == `VRS_CYC_PER_STEP) begin
                cadence_next = 2'h0;
            end else begin
                cadence_next = cnt + 2'h1;
            end
        end
    endfunction

    // R4 sample against accepted
    assign code_new = (voltage_ident_code != accepted_code);
    // R6 unchanged since sampling
    assign code_held = (voltage_ident_code == cand_r);
    // R7 step every second cycle
    assign step_due = (cadence_next(cyc_r) == 2'h0);
    // Reference still short of an accepted, non-shutdown target
    assign walk_left = !shutdown && (reference_mv != target_r);

    always @* begin
        state_nxt = state_r;
        cand_nxt = cand_r;
        acc_nxt = accepted_code;
        target_nxt = target_r;
        shut_nxt = shutdown;
        // R3 cycle boundary only
        if (cycle_tick) begin
            case (state_r)
                ST_IDLE: begin
                    // R4 sample and compare
                    if (code_new) begin
                        cand_nxt = voltage_ident_code;
                        // R5 hold one cycle
                        state_nxt = ST_VALID;
                    end
                end
                ST_VALID: begin
                    // R6 stable through window
                    if (code_held) begin
                        acc_nxt = cand_r;
                        // R2 shutdown on accept
                        shut_nxt = cand_shut;
                        // Shutdown leaves the reference where it was; restart resumes from there
                        if (!cand_shut) begin
                            target_nxt = cand_mv;
                            state_nxt = ST_STEP;
                        end else begin
                            state_nxt = ST_IDLE;
                        end
                    end else if (code_new) begin
                        // R6 changed code restarts window
                        cand_nxt = voltage_ident_code;
                    end else if (walk_left) begin
                        // A glitch back to the accepted code must not strand a half-finished walk
                        state_nxt = ST_STEP;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_STEP: begin
                    // R8 stop when equal
                    if (step_due && (ref_nxt == target_r)) begin
                        state_nxt = ST_IDLE;
                    end
                    // A new code mid-walk is sampled and validated; walking pauses meanwhile
                    if (code_new) begin
                        cand_nxt = voltage_ident_code;
                        state_nxt = ST_VALID;
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // R7 one step per two cycles
    always @* begin
        cyc_nxt = cyc_r;
        ref_nxt = reference_mv;
        if (cycle_tick) begin
            if (state_r == ST_VALID && code_held && !cand_shut) begin
                // Fresh cadence for a newly accepted target
                cyc_nxt = 2'h0;
            end else if (state_r == ST_STEP) begin
                cyc_nxt = cadence_next(cyc_r);
                if (step_due) begin
                    // R8 direction and stop
                    ref_nxt = step_toward(reference_mv, target_r);
                end
            end
        end
    end

    // Walk flag also covers a revalidation pause, so it only drops at the target or when a shutdown code is accepted
    always @* begin
        stepping_nxt = (state_nxt == ST_STEP);
        if (!shut_nxt && (ref_nxt != target_nxt)) begin
            stepping_nxt = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cand_r <= `VRS_CODE_RESET;
        end else if (ce) begin
            state_r <= state_nxt;
            cand_r <= cand_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            accepted_code <= `VRS_CODE_RESET;
            shutdown <= 1'b1;
            target_r <= `VRS_MV_BOTTOM;
        end else if (ce) begin
            accepted_code <= acc_nxt;
            shutdown <= shut_nxt;
            target_r <= target_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            cyc_r <= 2'h0;
            reference_mv <= `VRS_MV_BOTTOM;
        end else if (ce) begin
            cyc_r <= cyc_nxt;
            reference_mv <= ref_nxt;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            stepping <= 1'b0;
        end else if (ce) begin
            stepping <= stepping_nxt;
        end
    end
endmodule // vrs_reference_stepper
